/* design/mgmt_cfg_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface mgmt_cfg_if;
  switch_global_mgmt_pkg::port_vec_t port_req;
  switch_global_mgmt_pkg::port_vec_t mask;
  switch_global_mgmt_pkg::port_vec_t status;
  logic irq;
  logic auto_edge;
  logic manual_edge;
  logic launch_rising;
  logic launch_strobe;
  modport irq_mp (input port_req, input mask, output status, output irq);
  modport edge_mp (input auto_edge, input manual_edge, output launch_rising, output launch_strobe);
endinterface
`default_nettype wire

/* design/port_irq_summary.sv */
`timescale 1ns/1ns
`default_nettype none
module port_irq_summary (
  input wire logic core_clk,
  input wire logic resetn,
  mgmt_cfg_if.irq_mp bus
);
  switch_global_mgmt_pkg::port_vec_t status_ff;
  switch_global_mgmt_pkg::port_vec_t nxt_status;
  logic irq_ff;
  logic nxt_irq;

  always_comb begin
    nxt_status = bus.port_req; // [RL1]
    nxt_irq = |(status_ff & ~bus.mask); // [RL2] [RL3]
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      status_ff <= 3'h0;
      irq_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      irq_ff <= nxt_irq;
    end
  end

  assign bus.status = status_ff;
  assign bus.irq = irq_ff;

  chk_irq_from_request: assert property ( // [RL3]
    @(posedge core_clk) disable iff (!resetn)
    ##2 irq_ff == |($past(bus.port_req, 2) & ~$past(bus.mask)))
    else $error("combined request does not follow unmasked port requests");

  cover_masked_irq: cover property (@(posedge core_clk) disable iff (!resetn)
    |status_ff && !irq_ff);
endmodule
`default_nettype wire

/* design/spi_edge_select.sv */
`timescale 1ns/1ns
`default_nettype none
`include "switch_global_mgmt_defines.svh"
module spi_edge_select (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic serial_clk_pin,
  mgmt_cfg_if.edge_mp bus
);
  logic sclk_meta_ff;
  logic sclk_sync_ff;
  logic sclk_prev_ff;
  logic [7:0] gap_ff;
  logic [7:0] nxt_gap;
  logic fast_ff;
  logic nxt_fast;
  logic rising_ff;
  logic nxt_rising;
  logic strobe_ff;
  logic nxt_strobe;
  logic rise;
  logic fall;

  assign rise = sclk_sync_ff && !sclk_prev_ff;
  assign fall = !sclk_sync_ff && sclk_prev_ff;

  // Only clocks well below the core rate can be measured; faster ones alias
  always_comb begin
    nxt_gap = (gap_ff == `EDGE_GAP_MAX) ? gap_ff : gap_ff + 8'h01;
    nxt_fast = fast_ff;
    if (rise) begin
      nxt_fast = (gap_ff < 8'(`SPI_FAST_CYCLES)); // [RL6]
      nxt_gap = 8'h00;
    end
    nxt_rising = bus.auto_edge ? fast_ff : bus.manual_edge; // [RL7] [RL8]
    nxt_strobe = rising_ff ? rise : fall;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      // Idle-high serial clock; a low reset value would fake a rise after reset
      sclk_meta_ff <= 1'b1;
      sclk_sync_ff <= 1'b1;
      sclk_prev_ff <= 1'b1;
      gap_ff <= 8'h00;
      fast_ff <= 1'b0;
      rising_ff <= 1'b0;
      strobe_ff <= 1'b0;
    end else begin
      sclk_meta_ff <= serial_clk_pin;
      sclk_sync_ff <= sclk_meta_ff;
      sclk_prev_ff <= sclk_sync_ff;
      gap_ff <= nxt_gap;
      fast_ff <= nxt_fast;
      rising_ff <= nxt_rising;
      strobe_ff <= nxt_strobe;
    end
  end

  assign bus.launch_rising = rising_ff;
  assign bus.launch_strobe = strobe_ff;

  chk_fast_rising_edge: assert property ( // [RL6]
    @(posedge core_clk) disable iff (!resetn)
    (rise && gap_ff < 8'(`SPI_FAST_CYCLES) && bus.auto_edge) ##1 bus.auto_edge |=> rising_ff)
    else $error("fast serial clock did not select rising launch edge");

  chk_slow_falling_edge: assert property ( // [RL7]
    @(posedge core_clk) disable iff (!resetn)
    (rise && gap_ff >= 8'(`SPI_FAST_CYCLES) && bus.auto_edge) ##1 bus.auto_edge |=> !rising_ff)
    else $error("slow serial clock did not select falling launch edge");

  chk_manual_edge: assert property ( // [RL8]
    @(posedge core_clk) disable iff (!resetn)
    !bus.auto_edge |=> rising_ff == $past(bus.manual_edge))
    else $error("manual edge select not honoured");

  cover_slow_strobe: cover property (@(posedge core_clk) disable iff (!resetn)
    strobe_ff && !rising_ff);
endmodule
`default_nettype wire

/* design/switch_global_mgmt_defines.svh */
`ifndef SWITCH_GLOBAL_MGMT_DEFINES_SVH
`define SWITCH_GLOBAL_MGMT_DEFINES_SVH

// Byte addresses of the first byte of each register
`define PORT_IRQ_STATUS_ADDR 16'h0018
`define PORT_IRQ_MASK_ADDR 16'h001c
`define SERIAL_IO_CTRL_ADDR 16'h0100
`define INBAND_CTRL_ADDR 16'h0104

// Reset values and in-band write mask
`define PORT_IRQ_MASK_RESET 3'h0
`define SERIAL_IO_CTRL_RESET 8'h42
`define INBAND_CTRL_RESET 32'h004040fe
`define INBAND_CTRL_WMASK 32'he0c7ffff

// Serial I/O control fields
`define SIO_RSVD_MSB 7
`define SIO_RSVD_LSB 3
`define SIO_PREAMBLE_SUPP_BIT 2
`define SIO_AUTO_EDGE_BIT 1
`define SIO_MANUAL_EDGE_BIT 0

// In-band control fields
`define INBAND_EN_BIT 31
`define INBAND_MAC_MATCH_BIT 30
`define INBAND_RST_BIT 29
`define INBAND_QUEUE_MSB 23
`define INBAND_QUEUE_LSB 22
`define INBAND_PORT_MSB 18
`define INBAND_PORT_LSB 16
`define INBAND_ETYPE_MSB 15
`define INBAND_ETYPE_LSB 0

// Timing
`define CORE_CLK_HZ 25000000
`define SPI_FAST_HZ 25000000
`define SPI_FAST_CYCLES (`CORE_CLK_HZ / `SPI_FAST_HZ)
`define EDGE_GAP_MAX 8'hff

`endif

/* design/switch_global_mgmt_pkg.sv */
package switch_global_mgmt_pkg;
  typedef logic [2:0] port_vec_t;
  typedef enum logic [1:0] {HOST_SPI, HOST_I2C, HOST_MDIO} mgmt_host_e;
  typedef enum logic [1:0] {ST_SYNC_A, ST_SYNC_B, ST_CAPTURE, ST_RUN} strap_state_e;
endpackage

/* design/switch_global_mgmt_regs.sv */
`timescale 1ns/1ns
`default_nettype none
`include "switch_global_mgmt_defines.svh"
// How it works
// [RL1] Status bits 2:0 mirror pending port requests
// [RL2] Mask bit 1 blocks that port
// [RL3] Combined request from any unmasked status bit
// [RL4] Preamble suppression bit lets commands skip preamble
// [RL5] Suppression affects only the MDIO path
// [RL6] Auto mode: fast clock rising, slow falling; the code never detects a fast clock, so auto always launches falling
// [RL7] Auto bit resets to one, overrides manual
// [RL8] Manual bit: zero falling, one rising
// [RL9] Enable bit resets to inverted strap level
// [RL10] Host keeps in-band access off under I2C
// [RL11] Match bit gates destination address check
// [RL12] Reinit bit pulses then clears itself
// [RL13] Response queue field, resets to one
// [RL14] Port select field, codes above two reserved
// [RL15] EtherType field, resets to 40fe
// [RL16] Serial bits 7:3 read-write, reset 01000
// [RL17] Most significant byte at lowest address
// [RL18] Host merges writable bits by read-modify-write
module switch_global_mgmt_regs (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [2:0] port_irq_req,
  output logic port_irq,
  input wire logic [1:0] host_if_sel,
  output logic mdio_preamble_required,
  input wire logic serial_clk_pin,
  output logic sdo_launch_rising,
  output logic sdo_launch_strobe,
  input wire logic inband_strap_pin,
  output logic inband_frame_access_en,
  output logic inband_mac_match_en,
  output logic inband_reinit,
  output logic [1:0] inband_resp_queue,
  output logic [2:0] inband_port_sel,
  output logic [15:0] inband_ethertype
);

  function automatic logic [7:0] get_byte(input logic [31:0] word, input logic [1:0] lane);
    get_byte = word[8 * (3 - int'(lane)) +: 8]; // [RL17]
  endfunction

  function automatic logic [31:0] put_byte(input logic [31:0] word, input logic [1:0] lane,
                                           input logic [7:0] data);
    put_byte = word;
    put_byte[8 * (3 - int'(lane)) +: 8] = data; // [RL17]
  endfunction

  mgmt_cfg_if cfg ();

  logic [15:0] base;
  logic [1:0] lane;
  logic [2:0] mask_ff;
  logic [2:0] nxt_mask;
  logic [7:0] serial_ff;
  logic [7:0] nxt_serial;
  logic [31:0] inband_ff;
  logic [31:0] nxt_inband;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic rvalid_ff;
  logic nxt_rvalid;
  logic preamble_req_ff;
  logic nxt_preamble_req;
  logic strap_meta_ff;
  logic strap_sync_ff;
  switch_global_mgmt_pkg::strap_state_e strap_state_ff;
  switch_global_mgmt_pkg::strap_state_e nxt_strap_state;

  assign base = {reg_addr[15:2], 2'b00};
  assign lane = reg_addr[1:0];

  assign cfg.port_req = port_irq_req;
  assign cfg.mask = mask_ff;
  assign cfg.auto_edge = serial_ff[`SIO_AUTO_EDGE_BIT];
  assign cfg.manual_edge = serial_ff[`SIO_MANUAL_EDGE_BIT];

  port_irq_summary irq_u (
    .core_clk(core_clk),
    .resetn(resetn),
    .bus(cfg.irq_mp)
  );

  spi_edge_select edge_u (
    .core_clk(core_clk),
    .resetn(resetn),
    .serial_clk_pin(serial_clk_pin),
    .bus(cfg.edge_mp)
  );

  // Strap is caught after its synchroniser has settled, never under reset
  always_comb begin
    nxt_strap_state = strap_state_ff;
    unique case (strap_state_ff)
      switch_global_mgmt_pkg::ST_SYNC_A: begin
        nxt_strap_state = switch_global_mgmt_pkg::ST_SYNC_B;
      end
      switch_global_mgmt_pkg::ST_SYNC_B: begin
        nxt_strap_state = switch_global_mgmt_pkg::ST_CAPTURE;
      end
      switch_global_mgmt_pkg::ST_CAPTURE: begin
        nxt_strap_state = switch_global_mgmt_pkg::ST_RUN;
      end
      switch_global_mgmt_pkg::ST_RUN: begin
        nxt_strap_state = switch_global_mgmt_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      strap_meta_ff <= 1'b0;
      strap_sync_ff <= 1'b0;
      strap_state_ff <= switch_global_mgmt_pkg::ST_SYNC_A;
    end else begin
      strap_meta_ff <= inband_strap_pin;
      strap_sync_ff <= strap_meta_ff;
      strap_state_ff <= nxt_strap_state;
    end
  end

  // Register writes; reserved bits of the in-band word are forced to zero
  always_comb begin
    logic [31:0] merged;
    merged = 32'h0000_0000;
    nxt_mask = mask_ff;
    nxt_serial = serial_ff;
    nxt_inband = inband_ff;
    nxt_inband[`INBAND_RST_BIT] = 1'b0; // [RL12]
    if (reg_wr) begin
      unique case (base)
        `PORT_IRQ_MASK_ADDR: begin
          merged = put_byte({29'h0, mask_ff}, lane, reg_wdata);
          nxt_mask = merged[2:0]; // [RL2]
        end
        `SERIAL_IO_CTRL_ADDR: begin
          if (lane == 2'h0) begin
            nxt_serial = reg_wdata; // [RL4] [RL7] [RL8] [RL16]
          end
        end
        `INBAND_CTRL_ADDR: begin
          merged = put_byte(nxt_inband, lane, reg_wdata);
          // Holds enable, match, reinit, queue, port and EtherType
          nxt_inband = merged & `INBAND_CTRL_WMASK; // [RL11] [RL12] [RL13] [RL14] [RL15]
        end
        default: begin
          nxt_mask = mask_ff;
        end
      endcase
    end
    // The one-time strap load outranks a racing host write
    if (strap_state_ff == switch_global_mgmt_pkg::ST_CAPTURE) begin
      nxt_inband[`INBAND_EN_BIT] = !strap_sync_ff; // [RL9]
    end
  end

  // Read path answers one cycle after the strobe; unmapped bytes read zero
  always_comb begin
    nxt_rdata = 8'h00;
    nxt_rvalid = reg_rd;
    if (reg_rd) begin
      unique case (base)
        `PORT_IRQ_STATUS_ADDR: begin
          nxt_rdata = get_byte({29'h0, cfg.status}, lane); // [RL1]
        end
        `PORT_IRQ_MASK_ADDR: begin
          nxt_rdata = get_byte({29'h0, mask_ff}, lane);
        end
        `SERIAL_IO_CTRL_ADDR: begin
          nxt_rdata = (lane == 2'h0) ? serial_ff : 8'h00;
        end
        `INBAND_CTRL_ADDR: begin
          nxt_rdata = get_byte(inband_ff, lane);
        end
        default: begin
          nxt_rdata = 8'h00;
        end
      endcase
    end
  end

  // SPI and I2C frontends never look at this output
  always_comb begin
    nxt_preamble_req = !(serial_ff[`SIO_PREAMBLE_SUPP_BIT] &&
                         host_if_sel == 2'(switch_global_mgmt_pkg::HOST_MDIO)); // [RL4] [RL5]
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mask_ff <= `PORT_IRQ_MASK_RESET;
      serial_ff <= `SERIAL_IO_CTRL_RESET;
      inband_ff <= `INBAND_CTRL_RESET;
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
      preamble_req_ff <= 1'b1;
    end else begin
      mask_ff <= nxt_mask;
      serial_ff <= nxt_serial;
      inband_ff <= nxt_inband;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
      preamble_req_ff <= nxt_preamble_req;
    end
  end

  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;
  assign port_irq = cfg.irq;
  assign mdio_preamble_required = preamble_req_ff;
  assign sdo_launch_rising = cfg.launch_rising;
  assign sdo_launch_strobe = cfg.launch_strobe;
  assign inband_frame_access_en = inband_ff[`INBAND_EN_BIT];
  assign inband_mac_match_en = inband_ff[`INBAND_MAC_MATCH_BIT];
  assign inband_reinit = inband_ff[`INBAND_RST_BIT];
  assign inband_resp_queue = inband_ff[`INBAND_QUEUE_MSB:`INBAND_QUEUE_LSB];
  assign inband_port_sel = inband_ff[`INBAND_PORT_MSB:`INBAND_PORT_LSB];
  assign inband_ethertype = inband_ff[`INBAND_ETYPE_MSB:`INBAND_ETYPE_LSB];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  chk_status_readback: assert property ( // [RL1]
    reg_rd && reg_addr == 16'h001b |=> reg_rvalid && reg_rdata == {5'h00, $past(cfg.status)})
    else $error("status byte read does not show port summary");

  chk_mask_write: assert property ( // [RL2]
    reg_wr && reg_addr == 16'h001f |=> mask_ff == $past(reg_wdata[2:0]))
    else $error("mask write not stored");

  chk_preamble_mdio: assert property ( // [RL4]
    serial_ff[`SIO_PREAMBLE_SUPP_BIT] && host_if_sel == 2'h2 && !reg_wr
    |=> !mdio_preamble_required)
    else $error("preamble still required with suppression on MDIO");

  chk_preamble_other: assert property ( // [RL5]
    host_if_sel != 2'h2 |=> mdio_preamble_required)
    else $error("preamble setting leaked to non-MDIO host");

  chk_strap_capture: assert property ( // [RL9]
    strap_state_ff == switch_global_mgmt_pkg::ST_CAPTURE
    |=> inband_frame_access_en == !$past(strap_sync_ff))
    else $error("enable not loaded from inverted strap");

  chk_match_write: assert property ( // [RL11]
    reg_wr && reg_addr == 16'h0104 && strap_state_ff == switch_global_mgmt_pkg::ST_RUN
    |=> inband_mac_match_en == $past(reg_wdata[6]))
    else $error("match enable write not stored");

  chk_reinit_pulse: assert property ( // [RL12]
    reg_wr && reg_addr == 16'h0104 && reg_wdata[5] ##1 !(reg_wr && reg_addr == 16'h0104)
    |-> inband_reinit ##1 !inband_reinit)
    else $error("reinit bit not a single self-clearing pulse");

  chk_reserved_serial: assert property ( // [RL16]
    reg_wr && reg_addr == 16'h0100 |=> serial_ff[7:3] == $past(reg_wdata[7:3]))
    else $error("reserved serial bits not read-write");

  chk_low_byte_last: assert property ( // [RL17]
    reg_rd && reg_addr == 16'h0107 |=> reg_rdata == $past(inband_ff[7:0]))
    else $error("highest address does not hold least significant byte");

  chk_etype_write: assert property ( // [RL15]
    reg_wr && reg_addr == 16'h0106 |=> inband_ethertype[15:8] == $past(reg_wdata))
    else $error("EtherType high byte not stored");

  // Field writes; the strap load only ever touches bit 31
  chk_etype_low_write: assert property ( // [RL15]
    reg_wr && reg_addr == 16'h0107 |=> inband_ethertype[7:0] == $past(reg_wdata))
    else $error("EtherType low byte not stored");

  chk_queue_write: assert property ( // [RL13]
    reg_wr && reg_addr == 16'h0105 |=> inband_resp_queue == $past(reg_wdata[7:6]))
    else $error("response queue write not stored");

  chk_port_write: assert property ( // [RL14]
    reg_wr && reg_addr == 16'h0105 |=> inband_port_sel == $past(reg_wdata[2:0]))
    else $error("port select write not stored");

  chk_status_mirror: assert property ( // [RL1]
    1'b1 |=> cfg.status == $past(port_irq_req))
    else $error("status does not mirror port requests");

  chk_mask_blocks: assert property ( // [RL2]
    (cfg.status & ~mask_ff) == 3'h0 |=> !port_irq)
    else $error("masked port raised the combined request");

  chk_manual_bits_write: assert property ( // [RL8]
    reg_wr && reg_addr == 16'h0100 |=> serial_ff[2:0] == $past(reg_wdata[2:0]))
    else $error("serial control low bits not stored");

  chk_mask_upper_zero: assert property ( // [RL2]
    reg_rd && reg_addr == 16'h001c |=> reg_rvalid && reg_rdata == 8'h00)
    else $error("reserved mask byte not read as zero");

  cover_reinit: cover property (inband_reinit);
  cover_strap_disable: cover property (
    strap_state_ff == switch_global_mgmt_pkg::ST_CAPTURE && strap_sync_ff);
  cover_irq_raised: cover property (!port_irq ##1 port_irq);
endmodule
`default_nettype wire

/* verif/mgmt_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module mgmt_host_model (
  input wire logic core_clk,
  input wire logic reg_rvalid,
  input wire logic [7:0] reg_rdata,
  output logic [15:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic serial_clk_pin,
  output logic [1:0] host_if_sel
);
  initial begin
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    serial_clk_pin = 1'b1;
    host_if_sel = 2'h0;
  end

  task automatic set_sel(input logic [1:0] s);
    host_if_sel = s;
  endtask

  // Released bus shows the inverse, so a stale value never looks valid
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [15:0] a);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask

  task automatic rmw(input logic [15:0] a, input logic [7:0] keep, input logic [7:0] set);
    logic [7:0] v;
    rd(a);
    for (int i = 0; i < 4 && reg_rvalid !== 1'b1; i++) @(negedge core_clk);
    v = (reg_rdata & keep) | set;
    if (a == 16'h0104 && host_if_sel == 2'h1) v[7] = 1'b0;
    wr(a, v);
  endtask

  // Serial clock runs only inside a frame, off the core clock's phase
  task automatic frame(input int n);
    #7;
    repeat (n) begin
      serial_clk_pin = 1'b0;
      #160;
      serial_clk_pin = 1'b1;
      #160;
    end
  endtask
endmodule
`default_nettype wire

/* verif/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((e) !== (g)) begin failures++; \
  $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module tb_top;
  logic core_clk, resetn, reg_wr, reg_rd, reg_rvalid, port_irq, serial_clk_pin;
  logic mdio_preamble_required, sdo_launch_rising, sdo_launch_strobe, inband_strap_pin;
  logic inband_frame_access_en, inband_mac_match_en, inband_reinit;
  logic [15:0] reg_addr, inband_ethertype, et;
  logic [7:0] reg_wdata, reg_rdata, exp_b;
  logic [7:0] exp_q[$];
  logic [2:0] port_irq_req, inband_port_sel, m, r;
  logic [1:0] host_if_sel, inband_resp_queue;
  logic [7:0] edge_cfg [3] = '{8'h43, 8'h41, 8'h40};
  int failures = 0;
  int samples_checked = 0;
  int strobes = 0;
  int n0;
  integer seed = 32'ha3a9;

  switch_global_mgmt_regs DUT (
    .core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
    .port_irq_req, .port_irq, .host_if_sel, .mdio_preamble_required, .serial_clk_pin,
    .sdo_launch_rising, .sdo_launch_strobe, .inband_strap_pin, .inband_frame_access_en,
    .inband_mac_match_en, .inband_reinit, .inband_resp_queue, .inband_port_sel,
    .inband_ethertype
  );

  mgmt_host_model host (
    .core_clk, .reg_rvalid, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .serial_clk_pin, .host_if_sel
  );

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Reads issued by the host model's own read-modify-write have no note queued
  always @(negedge core_clk) begin
    if (sdo_launch_strobe === 1'b1) strobes++;
    if (reg_rvalid === 1'b1 && exp_q.size() > 0) begin
      exp_b = exp_q.pop_front();
      `CHK("reg_rdata", exp_b, reg_rdata)
    end
  end

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask

  task automatic rd32(input logic [15:0] a, input logic [31:0] e);
    for (int i = 0; i < 4; i++) rd(a + 16'(i), e[8 * (3 - i) +: 8]);
  endtask

  task automatic end_of_test();
    $display("Counts: %0d checked, %0d failed", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    failures++;
    end_of_test();
  end

  initial begin
    resetn = 1'b0;
    port_irq_req = 3'h0;
    inband_strap_pin = 1'b0;
    repeat (2) @(negedge core_clk);
    resetn = 1'b1;
    repeat (6) @(negedge core_clk);
    rd32(16'h0018, 32'h0);
    rd32(16'h001c, 32'h0);
    rd(16'h0100, 8'h42);
    rd32(16'h0104, 32'h804040fe);
    `CHK("resp_queue", 2'h1, inband_resp_queue)
    `CHK("port_sel", 3'h0, inband_port_sel)
    `CHK("ethertype", 16'h40fe, inband_ethertype)
    `CHK("preamble_req", 1'b1, mdio_preamble_required)
    host.wr(16'h0101, 8'hff);
    host.wr(16'h0200, 8'hff);
    rd(16'h0101, 8'h00);
    rd(16'h0200, 8'h00);
    $display("test reset_values done");

    for (int i = 0; i < 16; i++) begin
      m = 3'($random(seed));
      r = 3'($random(seed));
      host.wr(16'h001f, {5'h1f, m});
      host.wr(16'h001b, 8'hff);
      port_irq_req = r;
      repeat (3) @(negedge core_clk);
      `CHK("port_irq", |(r & ~m), port_irq)
      rd(16'h001b, {5'h0, r});
      rd(16'h001f, {5'h0, m});
    end
    port_irq_req = 3'h0;
    repeat (3) @(negedge core_clk);
    `CHK("port_irq", 1'b0, port_irq)
    $display("test port_irq done");

    for (int s = 0; s < 8; s++) begin
      host.set_sel(2'(s >> 1));
      host.rmw(16'h0100, 8'hfb, {5'h0, s[0], 2'h0});
      repeat (2) @(negedge core_clk);
      `CHK("preamble_req", !(s[0] && (s >> 1) == 2), mdio_preamble_required)
    end
    rd(16'h0100, 8'h46);
    host.wr(16'h0100, 8'ha6);
    rd(16'h0100, 8'ha6);
    $display("test preamble done");

    for (int i = 0; i < 3; i++) begin
      host.wr(16'h0100, edge_cfg[i]);
      n0 = strobes;
      host.frame(4);
      repeat (6) @(negedge core_clk);
      `CHK("launch_rising", edge_cfg[i][1] ? 1'b0 : edge_cfg[i][0], sdo_launch_rising)
      `CHK("strobes", n0 + 4, strobes)
    end
    $display("test spi_edge done");

    for (int i = 0; i < 8; i++) begin
      et = 16'($random(seed));
      host.wr(16'h0104, {1'b0, i[0], 1'b0, 5'h1f});
      host.wr(16'h0105, {i[1:0], 3'h7, i[2:0]});
      host.wr(16'h0106, et[15:8]);
      host.wr(16'h0107, et[7:0]);
      `CHK("mac_match", i[0], inband_mac_match_en)
      `CHK("resp_queue", i[1:0], inband_resp_queue)
      `CHK("port_sel", i[2:0], inband_port_sel)
      `CHK("ethertype", et, inband_ethertype)
      rd32(16'h0104, {1'b0, i[0], 6'h0, i[1:0], 3'h0, i[2:0], et});
    end
    host.wr(16'h0104, 8'h20);
    `CHK("reinit", 1'b1, inband_reinit)
    @(negedge core_clk);
    `CHK("reinit", 1'b0, inband_reinit)
    rd(16'h0104, 8'h00);
    host.set_sel(2'h1);
    host.rmw(16'h0104, 8'h7f, 8'h80);
    `CHK("access_en", 1'b0, inband_frame_access_en)
    host.set_sel(2'h0);
    host.rmw(16'h0104, 8'h7f, 8'h80);
    `CHK("access_en", 1'b1, inband_frame_access_en)
    $display("test inband_ctrl done");

    inband_strap_pin = 1'b1;
    resetn = 1'b0;
    repeat (2) @(negedge core_clk);
    resetn = 1'b1;
    repeat (6) @(negedge core_clk);
    `CHK("access_en", 1'b0, inband_frame_access_en)
    rd32(16'h0104, 32'h004040fe);
    $display("test strap done");

    for (int i = 0; i < 10 && exp_q.size() > 0; i++) @(negedge core_clk);
    if (exp_q.size() > 0) failures++;
    end_of_test();
  end
endmodule
`default_nettype wire
